// ### logic/ipv6_icmp_acl_matcher.sv
// Module: one access control entry matcher for IPv6 next-header, source, hop limit and ICMP
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
// Function
// - Specific next-header mode matches only frames whose next header equals configured value.
// - Any next-header mode ignores the next-header field.
// - ICMP, UDP, TCP modes require that protocol and enable its sub-filters.
// - Specific source mode compares only the low 32 source address bits.
// - Source mask zero bits are don't-care; compare masked frame and configured bits.
// - Any source mode never looks at the source address.
// - Hop limit: zero excludes nonzero hops, non-zero admits them, any ignores.
// - Specific ICMP type filter requires equal type; any ignores the type.
// - Specific ICMP code filter requires equal code; any ignores the code.
module ipv6_icmp_acl_matcher (
	input  wire logic                      sys_clk,
	input  wire logic                      nrst,
	input  wire logic [acl_match_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [acl_match_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [acl_match_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                      frm_valid,
	input  wire logic                      frm_is_ipv6,
	input  wire logic [7:0]                frm_next_hdr,
	input  wire logic [31:0]               frm_src_low,
	input  wire logic [7:0]                frm_hop_limit,
	input  wire logic [7:0]                frm_icmp_type,
	input  wire logic [7:0]                frm_icmp_code,
	output logic                           hit_valid,
	output logic                           hit,
	output logic                           icmp_sub_en,
	output logic                           udp_sub_en,
	output logic                           tcp_sub_en
);
	import acl_match_pkg::*;

	// ==========================================================
	// Configuration, hit counter and read-data registers
	logic [31:0] ctrl_reg, ctrl_next;
	logic [7:0]  nh_val_reg, nh_val_next;
	logic [31:0] src_reg, src_next;
	logic [31:0] mask_reg, mask_next;
	logic [15:0] icmp_reg, icmp_next;
	logic [31:0] hits_reg, hits_next;
	logic [31:0] rdata_reg, rdata_next;

	logic [2:0] nh_sel;
	logic       src_sel;
	logic [1:0] hop_sel;
	logic       type_en;
	logic       code_en;
	logic       entry_en;

	assign nh_sel   = ctrl_reg[NH_SEL_LO +: 3];
	assign src_sel  = ctrl_reg[SRC_SEL_BIT];
	assign hop_sel  = ctrl_reg[HOP_SEL_LO +: 2];
	assign type_en  = ctrl_reg[TYPE_EN_BIT];
	assign code_en  = ctrl_reg[CODE_EN_BIT];
	assign entry_en = ctrl_reg[ENTRY_EN_BIT];

	// ==========================================================
	// Match terms
	logic nh_ok, src_ok, hop_ok, type_ok, code_ok, icmp_mode, match;

	always_comb begin
		case (nh_sel)
			NH_ANY:      nh_ok = 1'b1;
			NH_SPECIFIC: nh_ok = (frm_next_hdr == nh_val_reg);
			NH_ICMP:     nh_ok = (frm_next_hdr == PROTO_ICMPV6);
			NH_UDP:      nh_ok = (frm_next_hdr == PROTO_UDP);
			NH_TCP:      nh_ok = (frm_next_hdr == PROTO_TCP);
			default:     nh_ok = 1'b0;
		endcase
	end

	// Any mode skips the address; a zero mask bit is don't-care
	logic [31:0] src_bit_ok;

	for (genvar b = 0; b < $bits(src_bit_ok); b++) begin : g_src_bit
		assign src_bit_ok[b] = !mask_reg[b] || (frm_src_low[b] == src_reg[b]);
	end

	assign src_ok = !src_sel || (&src_bit_ok);

	always_comb begin
		case (hop_sel)
			HOP_ANY:     hop_ok = 1'b1;
			HOP_ZERO:    hop_ok = (frm_hop_limit == ZERO_8);
			HOP_NONZERO: hop_ok = (frm_hop_limit != ZERO_8);
			default:     hop_ok = 1'b1;
		endcase
	end

	// ICMP sub-filters only take part when the ICMP selection is active
	assign icmp_mode = (nh_sel == NH_ICMP);
	// Type filter only counts in ICMP next-header mode
	always_comb begin
		type_ok = 1'b1;
		if (icmp_mode && type_en) begin
			type_ok = (frm_icmp_type == icmp_reg[ICMP_TYPE_LO +: 8]);
		end
	end

	// Code filter likewise
	always_comb begin
		code_ok = 1'b1;
		if (icmp_mode && code_en) begin
			code_ok = (frm_icmp_code == icmp_reg[ICMP_CODE_LO +: 8]);
		end
	end

	// Every enabled term must hold; a don't-care term reads as true
	assign match = entry_en
		&& frm_is_ipv6
		&& nh_ok
		&& src_ok
		&& hop_ok
		&& type_ok
		&& code_ok;

	// ==========================================================
	// Result registers
	// Outputs come from flops so the action logic sees one clean cycle
	logic       hit_valid_reg, hit_valid_next;
	logic       hit_reg, hit_next;
	logic [2:0] sub_reg, sub_next;

	always_comb begin
		hit_valid_next = frm_valid;
		hit_next       = frm_valid && match;
		sub_next       = {nh_sel == NH_TCP, nh_sel == NH_UDP, icmp_mode};
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hit_valid_reg <= 1'b0;
			hit_reg       <= 1'b0;
			sub_reg       <= 3'h0;
		end else begin
			hit_valid_reg <= hit_valid_next;
			hit_reg       <= hit_next;
			sub_reg       <= sub_next;
		end
	end

	// Sub-filter enables trail a mode change by one cycle
	assign hit_valid   = hit_valid_reg;
	assign hit         = hit_reg;
	assign icmp_sub_en = sub_reg[0];
	assign udp_sub_en  = sub_reg[1];
	assign tcp_sub_en  = sub_reg[2];

	// ==========================================================
	// Write decode
	// Status and unmapped offsets decode to no write
	// One strobe per cycle, so at most one enable is high
	logic wr_ctrl, wr_nh_val, wr_src, wr_mask, wr_icmp;

	assign wr_ctrl   = reg_wr && (reg_addr == OFF_CTRL);
	assign wr_nh_val = reg_wr && (reg_addr == OFF_NH_VAL);
	assign wr_src    = reg_wr && (reg_addr == OFF_SRC);
	assign wr_mask   = reg_wr && (reg_addr == OFF_MASK);
	assign wr_icmp   = reg_wr && (reg_addr == OFF_ICMP);

	// ==========================================================
	// Control register
	// All bits kept; unused ones read back as written
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_ctrl) begin
			ctrl_next = reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= CTRL_RST;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// ==========================================================
	// Next-header value
	// Only the low byte is stored; upper bits read zero
	always_comb begin
		nh_val_next = nh_val_reg;
		if (wr_nh_val) begin
			nh_val_next = reg_wdata[$bits(nh_val_reg)-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			nh_val_reg <= ZERO_8;
		end else begin
			nh_val_reg <= nh_val_next;
		end
	end

	// ==========================================================
	// Source address pattern
	// Low address word only; upper address bits never compared
	always_comb begin
		src_next = src_reg;
		if (wr_src) begin
			src_next = reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			src_reg <= ZERO_32;
		end else begin
			src_reg <= src_next;
		end
	end

	// ==========================================================
	// Source mask
	// Zero after reset, so a bare specific mode matches every source
	always_comb begin
		mask_next = mask_reg;
		if (wr_mask) begin
			mask_next = reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mask_reg <= ZERO_32;
		end else begin
			mask_reg <= mask_next;
		end
	end

	// ==========================================================
	// ICMP type and code values
	// Type in the low byte, code in the next
	always_comb begin
		icmp_next = icmp_reg;
		if (wr_icmp) begin
			icmp_next = reg_wdata[$bits(icmp_reg)-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			icmp_reg <= {2{ZERO_8}};
		end else begin
			icmp_reg <= icmp_next;
		end
	end

	// ==========================================================
	// Hit counter
	// Wraps silently; software takes differences
	always_comb begin
		hits_next = hits_reg;
		if (frm_valid && match) begin
			hits_next = hits_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hits_reg <= ZERO_32;
		end else begin
			hits_reg <= hits_next;
		end
	end

	// ==========================================================
	// Register reads
	// Data stand in the cycle after the strobe only, zero otherwise
	// Reads have no side effects, the counter included
	always_comb begin
		rdata_next = ZERO_32;
		if (reg_rd) begin
			case (reg_addr)
				OFF_CTRL:   rdata_next = ctrl_reg;
				OFF_NH_VAL: rdata_next = {24'h00_0000, nh_val_reg};
				OFF_SRC:    rdata_next = src_reg;
				OFF_MASK:   rdata_next = mask_reg;
				OFF_ICMP:   rdata_next = {16'h0000, icmp_reg};
				OFF_STAT:   rdata_next = hits_reg;
				default:    rdata_next = ZERO_32;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_reg <= ZERO_32;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
endmodule

// ### shared/acl_match_pkg.sv
// Package: register map, field codes and constants of the IPv6/ICMP entry matcher
package acl_match_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// Register offsets (one word each, at addresses 0x0, 0x4, 0x8, 0xC, 0x1 and 0x2)
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_NH_VAL = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_SRC    = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_MASK   = 4'hC;
	localparam logic [ADDR_W-1:0] OFF_ICMP   = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_STAT   = 4'h2;

	// Control register field positions
	localparam int NH_SEL_LO   = 0;
	localparam int SRC_SEL_BIT = 4;
	localparam int HOP_SEL_LO  = 8;
	localparam int TYPE_EN_BIT = 12;
	localparam int CODE_EN_BIT = 13;
	localparam int ENTRY_EN_BIT = 16;

	// ICMP register field positions
	localparam int ICMP_TYPE_LO = 0;
	localparam int ICMP_CODE_LO = 8;

	// Next-header filter selections
	localparam logic [2:0] NH_ANY      = 3'h0;
	localparam logic [2:0] NH_SPECIFIC = 3'h1;
	localparam logic [2:0] NH_ICMP     = 3'h2;
	localparam logic [2:0] NH_UDP      = 3'h3;
	localparam logic [2:0] NH_TCP      = 3'h4;

	// Hop-limit selections
	localparam logic [1:0] HOP_ANY     = 2'h0;
	localparam logic [1:0] HOP_ZERO    = 2'h1;
	localparam logic [1:0] HOP_NONZERO = 2'h2;

	// Protocol numbers carried in the next-header field
	localparam logic [7:0] PROTO_ICMPV6 = 8'h3A;
	localparam logic [7:0] PROTO_UDP    = 8'h11;
	localparam logic [7:0] PROTO_TCP    = 8'h06;

	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] ZERO_32  = 32'h0000_0000;
	localparam logic [7:0]  ZERO_8   = 8'h00;
endpackage

// ### test/acl_match_chk_sva.sv
// Checker of the entry matcher ports
`timescale 1ns/100ps
module acl_match_chk
	import acl_match_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       nrst,
	input wire logic       reg_wr,
	input wire logic       frm_valid,
	input wire logic       frm_is_ipv6,
	input wire logic [7:0] frm_next_hdr,
	input wire logic       hit_valid,
	input wire logic       hit,
	input wire logic       icmp_sub_en,
	input wire logic       udp_sub_en,
	input wire logic       tcp_sub_en
);
	// ====
	// Properties
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	property p_hv; frm_valid |=> hit_valid; endproperty
	a_hv: assert property (p_hv) else $error("no result after frame");
	property p_nhv; !frm_valid |=> !hit_valid; endproperty
	a_nhv: assert property (p_nhv) else $error("result without frame");
	property p_hq; hit |-> hit_valid; endproperty
	a_hq: assert property (p_hq) else $error("hit without result");
	property p_v4; frm_valid && !frm_is_ipv6 |=> !hit; endproperty
	a_v4: assert property (p_v4) else $error("non IPv6 hit");
	// Sub-enable lags a control write by one cycle, so skip that cycle
	property p_ic; frm_valid && icmp_sub_en && !$past(reg_wr) && frm_next_hdr != PROTO_ICMPV6 |=> !hit;
	endproperty
	a_ic: assert property (p_ic) else $error("ICMP mode hit on other protocol");
	property p_ud; frm_valid && udp_sub_en && !$past(reg_wr) && frm_next_hdr != PROTO_UDP |=> !hit;
	endproperty
	a_ud: assert property (p_ud) else $error("UDP mode hit on other protocol");
	property p_tc; frm_valid && tcp_sub_en && !$past(reg_wr) && frm_next_hdr != PROTO_TCP |=> !hit;
	endproperty
	a_tc: assert property (p_tc) else $error("TCP mode hit on other protocol");
	property p_one; $onehot0({icmp_sub_en, udp_sub_en, tcp_sub_en}); endproperty
	a_one: assert property (p_one) else $error("several sub-filters enabled");
endmodule
bind ipv6_icmp_acl_matcher acl_match_chk chk (
	.sys_clk      (sys_clk),
	.nrst         (nrst),
	.reg_wr       (reg_wr),
	.frm_valid    (frm_valid),
	.frm_is_ipv6  (frm_is_ipv6),
	.frm_next_hdr (frm_next_hdr),
	.hit_valid    (hit_valid),
	.hit          (hit),
	.icmp_sub_en  (icmp_sub_en),
	.udp_sub_en   (udp_sub_en),
	.tcp_sub_en   (tcp_sub_en)
);

// ### test/frame_src.sv
// Model of the header parser feeding parsed fields
`timescale 1ns/100ps
module frame_src (
	input  wire logic        sys_clk,
	output logic             frm_valid,
	output logic             frm_is_ipv6,
	output logic [7:0]       frm_next_hdr,
	output logic [31:0]      frm_src_low,
	output logic [7:0]       frm_hop_limit,
	output logic [7:0]       frm_icmp_type,
	output logic [7:0]       frm_icmp_code
);
	// ====
	// Driver
	logic [64:0] bus;
	assign {frm_is_ipv6, frm_next_hdr, frm_src_low, frm_hop_limit, frm_icmp_type, frm_icmp_code} = bus;
	initial begin
		frm_valid = 1'b0;
		bus = '0;
	end
	// Stale fields are inverted so a late sample never looks right
	task automatic send(input logic [64:0] f);
		@(posedge sys_clk);
		frm_valid <= 1'b1;
		bus <= f;
		@(posedge sys_clk);
		frm_valid <= 1'b0;
		bus <= ~f;
	endtask
endmodule

// ### test/ipv6_icmp_acl_matcher_tb_top.sv
// Testbench of the entry matcher
`timescale 1ns/100ps
module ipv6_icmp_acl_matcher_tb_top;
	import acl_match_pkg::*;
	// ====
	// Signals
	logic sys_clk, nrst, reg_wr, reg_rd, hit_valid, hit, icmp_sub_en, udp_sub_en, tcp_sub_en;
	logic frm_valid, frm_is_ipv6, v6;
	logic [7:0] frm_next_hdr, frm_hop_limit, frm_icmp_type, frm_icmp_code, nh, hl, ty, cd;
	logic [31:0] frm_src_low, reg_wdata, reg_rdata, hits, sa;
	logic [3:0] reg_addr;
	int fail_count, comparisons;
	ipv6_icmp_acl_matcher dut (
		.sys_clk       (sys_clk),
		.nrst          (nrst),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_rdata     (reg_rdata),
		.frm_valid     (frm_valid),
		.frm_is_ipv6   (frm_is_ipv6),
		.frm_next_hdr  (frm_next_hdr),
		.frm_src_low   (frm_src_low),
		.frm_hop_limit (frm_hop_limit),
		.frm_icmp_type (frm_icmp_type),
		.frm_icmp_code (frm_icmp_code),
		.hit_valid     (hit_valid),
		.hit           (hit),
		.icmp_sub_en   (icmp_sub_en),
		.udp_sub_en    (udp_sub_en),
		.tcp_sub_en    (tcp_sub_en)
	);
	frame_src src (
		.sys_clk       (sys_clk),
		.frm_valid     (frm_valid),
		.frm_is_ipv6   (frm_is_ipv6),
		.frm_next_hdr  (frm_next_hdr),
		.frm_src_low   (frm_src_low),
		.frm_hop_limit (frm_hop_limit),
		.frm_icmp_type (frm_icmp_type),
		.frm_icmp_code (frm_icmp_code)
	);
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// ====
	// Tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e, "reg_rdata");
		// Read data must fall back to zero after its one cycle
		@(posedge sys_clk);
		#1 chk(reg_rdata, 32'h0000_0000, "reg_rdata_idle");
	endtask
	task automatic cfg(input logic [2:0] m, input logic s, input logic [1:0] h, input logic t, c);
		wr(OFF_CTRL, {15'h0000, 1'b1, 2'b0, c, t, 2'b0, h, 3'b0, s, 1'b0, m});
	endtask
	task automatic frm(input logic e);
		src.send({v6, nh, sa, hl, ty, cd});
		#1 chk(hit_valid, 1'b1, "hit_valid");
		chk(hit, e, "hit");
		hits += e;
	endtask
	task automatic t_nh;
		logic [2:0] md[3] = '{NH_ICMP, NH_UDP, NH_TCP};
		logic [7:0] pr[3] = '{PROTO_ICMPV6, PROTO_UDP, PROTO_TCP};
		cfg(NH_SPECIFIC, 1'b0, HOP_ANY, 1'b0, 1'b0);
		wr(OFF_NH_VAL, 32'h0000_00FF);
		nh = 8'hFF;
		frm(1'b1);
		nh = 8'hFE;
		frm(1'b0);
		cfg(NH_ANY, 1'b0, HOP_ANY, 1'b0, 1'b0);
		frm(1'b1);
		for (int k = 0; k < 3; k++) begin
			cfg(md[k], 1'b0, HOP_ANY, 1'b0, 1'b0);
			nh = pr[k];
			frm(1'b1);
			chk({icmp_sub_en, udp_sub_en, tcp_sub_en}, 3'b100 >> k, "sub_en");
			nh = pr[k] ^ 8'h01;
			frm(1'b0);
		end
		cfg(3'h5, 1'b0, HOP_ANY, 1'b0, 1'b0);
		frm(1'b0);
	endtask
	task automatic t_src;
		cfg(NH_ANY, 1'b1, HOP_ANY, 1'b0, 1'b0);
		wr(OFF_SRC, 32'h2001_0003);
		wr(OFF_MASK, 32'hFFFF_FFFE);
		sa = 32'h2001_0002;
		frm(1'b1);
		sa = 32'hA001_0003;
		frm(1'b0);
		wr(OFF_MASK, 32'h0000_0000);
		frm(1'b1);
		wr(OFF_MASK, 32'hFFFF_FFFF);
		cfg(NH_ANY, 1'b0, HOP_ANY, 1'b0, 1'b0);
		frm(1'b1);
	endtask
	task automatic t_hop;
		cfg(NH_ANY, 1'b0, HOP_ZERO, 1'b0, 1'b0);
		hl = 8'h00;
		frm(1'b1);
		hl = 8'h01;
		frm(1'b0);
		cfg(NH_ANY, 1'b0, HOP_NONZERO, 1'b0, 1'b0);
		hl = 8'hFF;
		frm(1'b1);
		cfg(NH_ANY, 1'b0, HOP_ANY, 1'b0, 1'b0);
		frm(1'b1);
		cfg(NH_ANY, 1'b0, 2'h3, 1'b0, 1'b0);
		frm(1'b1);
		wr(OFF_CTRL, CTRL_RST);
		frm(1'b0);
	endtask
	task automatic t_icmp;
		cfg(NH_ICMP, 1'b0, HOP_ANY, 1'b1, 1'b1);
		wr(OFF_ICMP, 32'h0000_0080);
		{nh, ty, cd} = {PROTO_ICMPV6, 16'h8000};
		frm(1'b1);
		ty = 8'h81;
		frm(1'b0);
		{ty, cd} = 16'h80FF;
		frm(1'b0);
		cfg(NH_ICMP, 1'b0, HOP_ANY, 1'b1, 1'b0);
		frm(1'b1);
		cfg(NH_ICMP, 1'b0, HOP_ANY, 1'b0, 1'b1);
		{ty, cd} = 16'h00FF;
		frm(1'b0);
		cd = 8'h00;
		frm(1'b1);
		v6 = 1'b0;
		frm(1'b0);
	endtask
	task automatic tally_and_finish;
		if (fail_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ====
	// Sequence
	initial begin
		{nrst, reg_wr, reg_rd, reg_addr, reg_wdata, hits} = '0;
		{v6, nh, sa, hl, ty, cd} = {1'b1, 64'h0000_0000_0000_0000};
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(OFF_CTRL, CTRL_RST);
		rd(4'h3, 32'h0000_0000);
		t_nh();
		t_src();
		t_hop();
		t_icmp();
		rd(OFF_STAT, hits);
		wr(OFF_STAT, 32'h0000_0055);
		rd(OFF_STAT, hits);
		tally_and_finish();
	end
endmodule
